// ===== inc/vcc_pkg.sv
// Purpose: Shared constants and carriers for the child page counter leaf unit.
// Assumes: 32-bit AHB-Lite register access, word-aligned registers.
// Notes: Every register offset is a byte address on the bus.
`default_nettype none
package vcc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LEAF = 8'h04;
  localparam logic [7:0] OFF_TGT_LO = 8'h08;
  localparam logic [7:0] OFF_TGT_HI = 8'h0C;
  localparam logic [7:0] OFF_PAR_LO = 8'h10;
  localparam logic [7:0] OFF_PAR_HI = 8'h14;
  localparam logic [7:0] OFF_DS_LIMIT = 8'h18;
  localparam logic [7:0] OFF_BASE_LO = 8'h1C;
  localparam logic [7:0] OFF_BASE_HI = 8'h20;
  localparam logic [7:0] OFF_RES_LO = 8'h24;
  localparam logic [7:0] OFF_RES_HI = 8'h28;
  localparam logic [7:0] OFF_FLAGS = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_FEATURE = 8'h34;
  localparam logic [7:0] OFF_META_SEL = 8'h38;
  localparam logic [7:0] OFF_META = 8'h3C;
  localparam logic [7:0] OFF_CNT_LO = 8'h40;
  localparam logic [7:0] OFF_CNT_HI = 8'h44;
  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE64 = 1;
  localparam int CTRL_DS_UNUSABLE = 2;
  localparam int CTRL_CPL_LSB = 4;
  // Leaf indices and the feature bit that advertises both counter leaves.
  localparam logic [31:0] LEAF_DEC = 32'h0000_0000;
  localparam logic [31:0] LEAF_INC = 32'h0000_0001;
  localparam logic [31:0] FEATURE_VALUE = 32'h0000_0020;
  // Privilege level at which the leaves may run.
  localparam logic [1:0] CPL_KERNEL = 2'h0;
  // Page geometry: 4K pages.
  localparam int PAGE_SHIFT = 12;
  localparam logic [11:0] PAGE_OFFSET_ZERO = 12'h000;
  // Top canonical bit in 64-bit mode.
  localparam int CANON_MSB = 47;
  // Page type encodings held in the page metadata map.
  localparam logic [2:0] regular_page_type = 3'h0;
  localparam logic [2:0] control_structure_page_type = 3'h1;
  localparam logic [2:0] thread_control_page_type = 3'h2;
  localparam logic [2:0] trimmed_page_type = 3'h4;
  localparam logic [2:0] first_shadow_stack_page_type = 3'h5;
  localparam logic [2:0] later_shadow_stack_page_type = 3'h6;
  // Fault kinds reported in the status register.
  typedef enum logic [1:0] {
    VCC_FLT_NONE = 2'h0,
    VCC_FLT_GP = 2'h1,
    VCC_FLT_PF = 2'h2
  } vcc_fault_t;
  // One entry of the page metadata map.
  typedef struct packed {
    logic [15:0] parent_page;
    logic [4:0] spare;
    logic [2:0] page_type;
    logic [5:0] spare_lo;
    logic modified;
    logic valid;
  } vcc_meta_t;
  // Arithmetic flag image, cleared when a leaf completes without a fault, except the zero flag.
  typedef struct packed {
    logic sign_flag;
    logic overflow_flag;
    logic auxiliary_carry_flag;
    logic parity_flag;
    logic zero_flag;
    logic carry_flag;
  } vcc_flags_t;
  localparam vcc_flags_t FLAGS_RESET = '0;
endpackage
`default_nettype wire

// ===== rtl/vcc_leaf_unit.sv
// Purpose: Runs the child count decrement and increment leaves.
// Assumes: Data segment base is zero and linear addresses equal physical addresses.
// Notes: Protected page memory is modelled as PAGES contiguous 4K pages from a base.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
// Contract
// (RULE_01) Leaf 01H increments; feature bit 5 set.
// (RULE_02) Leaf 00H decrements the child counter.
// (RULE_03) Runs only at privilege level zero.
// (RULE_04) Operands use data segment, no override.
// (RULE_05) Unaligned target gives protection fault zero.
// (RULE_06) Target outside protected memory: page fault.
// (RULE_07) Parent outside protected memory: page fault.
// (RULE_08) Busy target: zero flag, conflict code, finish.
// (RULE_09) Invalid target metadata gives page fault.
// (RULE_10) Ordinary page types take parent from metadata.
// (RULE_11) Control structure is its own parent; else fault.
// (RULE_12) Parent mismatch gives protection fault zero.
// (RULE_13) Decrement; underflow restores, flags invalid counter.
// (RULE_14) Increment without overflow check, return zero.
// (RULE_15) Zero flag only on conflict or underflow.
// (RULE_16) Completion clears carry, parity, aux, overflow, sign.
// (RULE_17) Working counter and parent held 64 bits.
// (RULE_18) Target shared, parent concurrent for conflicts.
// (RULE_19) No conflict against other listed operations.
// (RULE_20) Grant target read/write, parent enclave read.
// (RULE_21) 32-bit mode: limit, unusable, alignment faults.
// (RULE_22) 64-bit mode: non-canonical address faults.
// (RULE_23) Access fault or non-control parent: page fault.
// (RULE_24) Checks run in order; first failure reported.
module vcc_leaf_unit #(
  parameter int PAGES = 16,
  parameter logic [63:0] PAGE_CONFLICT_CODE = 64'h0000_0000_0000_0001,
  parameter logic [63:0] INVALID_COUNTER_CODE = 64'h0000_0000_0000_0002
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic op_busy,
  output logic target_rw_grant,
  output logic parent_read_grant
);
  localparam int IDXW = $clog2(PAGES);

  // Page index width must fit the metadata parent field.
  if (PAGES < 2 || PAGES > 65536)
  begin : g_bad_pages
    $error("PAGES must lie between 2 and 65536.");
  end

  // One-hot execution states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_UPDATE = 5'b00100,
    ST_RESTORE = 5'b01000,
    ST_DONE = 5'b10000
  } vcc_state_t;

  vcc_state_t state; // Current execution state.
  vcc_state_t next_state; // Next execution state.

  // Bus data phase bookkeeping.
  logic dp_valid; // A transfer is in its data phase.
  logic dp_write; // The data phase is a write.
  logic [7:0] dp_addr; // Byte offset captured in the address phase.
  logic rd_stage; // Read data has been loaded into hrdata.

  // Software visible registers.
  logic mode64; // Operands use 64-bit addressing rules.
  logic ds_unusable; // The data segment is marked unusable.
  logic [1:0] cpl; // Current privilege level of the issuing code.
  logic [31:0] leaf_index_register; // Leaf selector.
  logic [63:0] target_page_register; // Target page effective address.
  logic [63:0] parent_address_register; // Parent structure effective address.
  logic [31:0] ds_limit; // Data segment limit for 32-bit mode.
  logic [63:0] mem_base; // Base of protected page memory.
  logic [63:0] result_register; // Leaf return code.
  vcc_pkg::vcc_flags_t flags; // Arithmetic flag image.
  vcc_pkg::vcc_fault_t fault_kind; // Fault raised by the last leaf.
  logic enclave_fault_error_bit; // Page fault came from enclave checks.
  logic op_done; // Last leaf has finished.
  logic [IDXW-1:0] meta_sel; // Entry picked for software access.

  // Page metadata map and per-page child counters.
  vcc_pkg::vcc_meta_t page_metadata_map [PAGES];
  logic [63:0] virtual_child_counter [PAGES];

  // Operation working values.
  logic [63:0] resolved_parent_address; // Parent physical address.
  logic [63:0] counter_working_value; // Counter value before the update.
  logic [IDXW-1:0] par_idx_q; // Counter slot being updated.
  logic is_dec; // Latched leaf is the decrement.

  // Bus strobes.
  logic addr_phase;
  logic wr_en;
  logic start_req;
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_en = dp_valid && dp_write;
  assign start_req = wr_en && (dp_addr == vcc_pkg::OFF_CTRL) && hwdata[vcc_pkg::CTRL_START];

  // Reads take one wait state so hrdata always comes from a flip-flop and sees prior writes.
  assign hreadyout = !(dp_valid && !dp_write && !rd_stage);
  assign hresp = 1'b0;
  assign op_busy = !state[0];
  // Target gets non-enclave read/write, parent only enclave read, while a leaf runs.
  assign target_rw_grant = op_busy; // RULE_20
  assign parent_read_grant = op_busy; // RULE_20

  // Address phase capture; hsize is ignored as only words are served.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      rd_stage <= 1'b0;
    end
    else if (clk_en)
    begin
      if (hreadyout)
      begin
        dp_valid <= addr_phase;
        dp_write <= hwrite;
        dp_addr <= haddr[7:0];
        rd_stage <= 1'b0;
      end
      else
      begin
        rd_stage <= 1'b1;
      end
    end
  end

  // Read data mux, loaded during the wait state; unmapped offsets read zero.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (clk_en && dp_valid && !dp_write && !rd_stage)
    begin
      if (dp_addr == vcc_pkg::OFF_CTRL)
        hrdata <= {26'h000_0000, cpl, 1'b0, ds_unusable, mode64, 1'b0};
      else if (dp_addr == vcc_pkg::OFF_LEAF)
        hrdata <= leaf_index_register;
      else if (dp_addr == vcc_pkg::OFF_TGT_LO)
        hrdata <= target_page_register[31:0];
      else if (dp_addr == vcc_pkg::OFF_TGT_HI)
        hrdata <= target_page_register[63:32];
      else if (dp_addr == vcc_pkg::OFF_PAR_LO)
        hrdata <= parent_address_register[31:0];
      else if (dp_addr == vcc_pkg::OFF_PAR_HI)
        hrdata <= parent_address_register[63:32];
      else if (dp_addr == vcc_pkg::OFF_DS_LIMIT)
        hrdata <= ds_limit;
      else if (dp_addr == vcc_pkg::OFF_BASE_LO)
        hrdata <= mem_base[31:0];
      else if (dp_addr == vcc_pkg::OFF_BASE_HI)
        hrdata <= mem_base[63:32];
      else if (dp_addr == vcc_pkg::OFF_RES_LO)
        hrdata <= result_register[31:0];
      else if (dp_addr == vcc_pkg::OFF_RES_HI)
        hrdata <= result_register[63:32];
      else if (dp_addr == vcc_pkg::OFF_FLAGS)
        hrdata <= {26'h000_0000, flags};
      else if (dp_addr == vcc_pkg::OFF_STATUS)
        hrdata <= {27'h000_0000, enclave_fault_error_bit, fault_kind, op_done, op_busy};
      else if (dp_addr == vcc_pkg::OFF_FEATURE)
        hrdata <= vcc_pkg::FEATURE_VALUE; // RULE_01
      else if (dp_addr == vcc_pkg::OFF_META_SEL)
        hrdata <= 32'(meta_sel);
      else if (dp_addr == vcc_pkg::OFF_META)
        hrdata <= page_metadata_map[meta_sel];
      else if (dp_addr == vcc_pkg::OFF_CNT_LO)
        hrdata <= virtual_child_counter[meta_sel][31:0];
      else if (dp_addr == vcc_pkg::OFF_CNT_HI)
        hrdata <= virtual_child_counter[meta_sel][63:32];
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // Operand and environment registers; they are frozen while a leaf runs.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode64 <= 1'b0;
      ds_unusable <= 1'b0;
      cpl <= vcc_pkg::CPL_KERNEL;
      leaf_index_register <= 32'h0000_0000;
      target_page_register <= 64'h0000_0000_0000_0000;
      parent_address_register <= 64'h0000_0000_0000_0000;
      ds_limit <= 32'hFFFF_FFFF;
      mem_base <= 64'h0000_0000_0000_0000;
      meta_sel <= '0;
    end
    else if (clk_en && wr_en && !op_busy)
    begin
      if (dp_addr == vcc_pkg::OFF_CTRL)
      begin
        mode64 <= hwdata[vcc_pkg::CTRL_MODE64];
        ds_unusable <= hwdata[vcc_pkg::CTRL_DS_UNUSABLE];
        cpl <= hwdata[vcc_pkg::CTRL_CPL_LSB +: 2];
      end
      else if (dp_addr == vcc_pkg::OFF_LEAF)
        leaf_index_register <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_TGT_LO)
        target_page_register[31:0] <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_TGT_HI)
        target_page_register[63:32] <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_PAR_LO)
        parent_address_register[31:0] <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_PAR_HI)
        parent_address_register[63:32] <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_DS_LIMIT)
        ds_limit <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_BASE_LO)
        mem_base[31:0] <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_BASE_HI)
        mem_base[63:32] <= hwdata;
      else if (dp_addr == vcc_pkg::OFF_META_SEL)
        meta_sel <= hwdata[IDXW-1:0];
    end
  end

  // Operand decode from a zero data segment base; no overrides exist.
  logic [63:0] tgt_off; // RULE_04
  logic [63:0] par_off; // RULE_04
  logic tgt_in;
  logic par_in;
  logic [IDXW-1:0] tgt_idx;
  logic [IDXW-1:0] par_idx;
  vcc_pkg::vcc_meta_t tgt_meta;
  vcc_pkg::vcc_meta_t par_meta;
  assign tgt_off = target_page_register - mem_base;
  assign par_off = parent_address_register - mem_base;
  assign tgt_in = (target_page_register >= mem_base) &&
                  ((tgt_off >> vcc_pkg::PAGE_SHIFT) < 64'(PAGES));
  assign par_in = (parent_address_register >= mem_base) &&
                  ((par_off >> vcc_pkg::PAGE_SHIFT) < 64'(PAGES));
  assign tgt_idx = tgt_off[vcc_pkg::PAGE_SHIFT +: IDXW];
  assign par_idx = par_off[vcc_pkg::PAGE_SHIFT +: IDXW];
  assign tgt_meta = page_metadata_map[tgt_idx];
  assign par_meta = page_metadata_map[par_idx];

  // Address form checks for both operating modes.
  logic tgt_noncanon;
  logic par_noncanon;
  logic seg_bad;
  logic misaligned;
  assign tgt_noncanon = !(&target_page_register[63:vcc_pkg::CANON_MSB]) &&
                        (|target_page_register[63:vcc_pkg::CANON_MSB]);
  assign par_noncanon = !(&parent_address_register[63:vcc_pkg::CANON_MSB]) &&
                        (|parent_address_register[63:vcc_pkg::CANON_MSB]);
  assign seg_bad = mode64 ? (tgt_noncanon || par_noncanon) : // RULE_22
                   (ds_unusable || (|target_page_register[63:32]) || (|parent_address_register[63:32]) ||
                    (target_page_register[31:0] > ds_limit) ||
                    (parent_address_register[31:0] > ds_limit)); // RULE_21
  assign misaligned = (target_page_register[11:0] != vcc_pkg::PAGE_OFFSET_ZERO) || // RULE_05
                      (parent_address_register[11:0] != vcc_pkg::PAGE_OFFSET_ZERO); // RULE_21

  // Ordered checks; the first failing one decides the outcome.
  vcc_pkg::vcc_fault_t chk_fault;
  logic chk_efb;
  logic chk_conflict;
  logic [63:0] chk_parent;
  always_comb
  begin
    chk_fault = vcc_pkg::VCC_FLT_NONE;
    chk_efb = 1'b0;
    chk_conflict = 1'b0;
    chk_parent = 64'h0000_0000_0000_0000;
    // A leaf other than the two counter leaves is refused as well.
    if (cpl != vcc_pkg::CPL_KERNEL ||
        (leaf_index_register != vcc_pkg::LEAF_DEC && leaf_index_register != vcc_pkg::LEAF_INC))
      chk_fault = vcc_pkg::VCC_FLT_GP; // RULE_03
    else if (seg_bad || misaligned)
      chk_fault = vcc_pkg::VCC_FLT_GP; // RULE_24
    else if (!tgt_in || !par_in)
    begin
      chk_fault = vcc_pkg::VCC_FLT_PF; // RULE_06 RULE_07
      chk_efb = 1'b1;
    end
    // Only the target is shared; the parent is concurrent and never conflicts.
    else if (tgt_meta.modified)
      chk_conflict = 1'b1; // RULE_08 RULE_18 RULE_19
    else if (!tgt_meta.valid)
    begin
      chk_fault = vcc_pkg::VCC_FLT_PF; // RULE_09
      chk_efb = 1'b1;
    end
    else
    begin
      if (tgt_meta.page_type == vcc_pkg::regular_page_type ||
          tgt_meta.page_type == vcc_pkg::thread_control_page_type ||
          tgt_meta.page_type == vcc_pkg::trimmed_page_type ||
          tgt_meta.page_type == vcc_pkg::first_shadow_stack_page_type ||
          tgt_meta.page_type == vcc_pkg::later_shadow_stack_page_type)
        chk_parent = mem_base + {36'h0_0000_0000, tgt_meta.parent_page, vcc_pkg::PAGE_OFFSET_ZERO}; // RULE_10
      else if (tgt_meta.page_type == vcc_pkg::control_structure_page_type)
        chk_parent = target_page_register; // RULE_11
      else
      begin
        chk_fault = vcc_pkg::VCC_FLT_PF; // RULE_11
        chk_efb = 1'b1;
      end
      if (chk_fault == vcc_pkg::VCC_FLT_NONE)
      begin
        if (!par_meta.valid || par_meta.page_type != vcc_pkg::control_structure_page_type)
        begin
          chk_fault = vcc_pkg::VCC_FLT_PF; // RULE_23
          chk_efb = 1'b1;
        end
        else if (chk_parent != parent_address_register)
          chk_fault = vcc_pkg::VCC_FLT_GP; // RULE_12
      end
    end
  end

  // Execution state machine.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start_req)
          next_state = ST_CHECK;
      ST_CHECK:
        if (chk_fault != vcc_pkg::VCC_FLT_NONE || chk_conflict)
          next_state = ST_DONE; // RULE_08
        else
          next_state = ST_UPDATE;
      ST_UPDATE:
        if (is_dec && counter_working_value == 64'h0000_0000_0000_0000)
          next_state = ST_RESTORE; // RULE_13
        else
          next_state = ST_DONE;
      ST_RESTORE:
        next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= ST_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // Working values, latched in the check state as 64-bit quantities.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      resolved_parent_address <= 64'h0000_0000_0000_0000;
      counter_working_value <= 64'h0000_0000_0000_0000;
      par_idx_q <= '0;
      is_dec <= 1'b0;
    end
    else if (clk_en && state == ST_CHECK)
    begin
      resolved_parent_address <= chk_parent; // RULE_17
      counter_working_value <= virtual_child_counter[par_idx]; // RULE_17
      par_idx_q <= par_idx;
      is_dec <= (leaf_index_register == vcc_pkg::LEAF_DEC); // RULE_02
    end
  end

  // Counter store. Leaf updates are single-writer so they are atomic; software
  // writes are dropped while a leaf runs to keep the read-modify-write locked.
  always_ff @(posedge hclk)
  begin
    if (clk_en)
    begin
      if (state == ST_UPDATE)
      begin
        if (is_dec)
          virtual_child_counter[par_idx_q] <= counter_working_value - 64'h0000_0000_0000_0001; // RULE_13
        else
          virtual_child_counter[par_idx_q] <= counter_working_value + 64'h0000_0000_0000_0001; // RULE_14
      end
      else if (state == ST_RESTORE)
        virtual_child_counter[par_idx_q] <= counter_working_value; // RULE_13
      else if (wr_en && !op_busy && dp_addr == vcc_pkg::OFF_CNT_LO)
        virtual_child_counter[meta_sel][31:0] <= hwdata;
      else if (wr_en && !op_busy && dp_addr == vcc_pkg::OFF_CNT_HI)
        virtual_child_counter[meta_sel][63:32] <= hwdata;
    end
  end

  // Metadata is loaded by software only; the leaves never alter it.
  always_ff @(posedge hclk)
  begin
    if (clk_en && wr_en && !op_busy && dp_addr == vcc_pkg::OFF_META)
      page_metadata_map[meta_sel] <= hwdata;
  end

  // Result, flags and fault report. A fault leaves result and flags untouched.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      result_register <= 64'h0000_0000_0000_0000;
      flags <= vcc_pkg::FLAGS_RESET;
      fault_kind <= vcc_pkg::VCC_FLT_NONE;
      enclave_fault_error_bit <= 1'b0;
      op_done <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start_req && !op_busy)
      begin
        op_done <= 1'b0;
        fault_kind <= vcc_pkg::VCC_FLT_NONE;
        enclave_fault_error_bit <= 1'b0;
      end
      else if (state == ST_CHECK && chk_fault != vcc_pkg::VCC_FLT_NONE)
      begin
        fault_kind <= chk_fault; // RULE_24
        enclave_fault_error_bit <= chk_efb;
      end
      else if (state == ST_CHECK && chk_conflict)
      begin
        result_register <= PAGE_CONFLICT_CODE; // RULE_08
        flags.zero_flag <= 1'b1; // RULE_15
      end
      else if (state == ST_UPDATE)
      begin
        result_register <= 64'h0000_0000_0000_0000; // RULE_14
        flags.zero_flag <= 1'b0; // RULE_15
      end
      else if (state == ST_RESTORE)
      begin
        result_register <= INVALID_COUNTER_CODE; // RULE_13
        flags.zero_flag <= 1'b1; // RULE_15
      end
      else if (state == ST_DONE)
      begin
        op_done <= 1'b1;
        if (fault_kind == vcc_pkg::VCC_FLT_NONE)
        begin
          flags.carry_flag <= 1'b0; // RULE_16
          flags.parity_flag <= 1'b0; // RULE_16
          flags.auxiliary_carry_flag <= 1'b0; // RULE_16
          flags.overflow_flag <= 1'b0; // RULE_16
          flags.sign_flag <= 1'b0; // RULE_16
        end
      end
      else if (wr_en && !op_busy && dp_addr == vcc_pkg::OFF_RES_LO)
        result_register[31:0] <= hwdata;
      else if (wr_en && !op_busy && dp_addr == vcc_pkg::OFF_RES_HI)
        result_register[63:32] <= hwdata;
      else if (wr_en && !op_busy && dp_addr == vcc_pkg::OFF_FLAGS)
        flags <= hwdata[5:0];
    end
  end
endmodule // vcc_leaf_unit
`default_nettype wire

// ===== dv/vcc_leaf_chk.sv
// Purpose: Bus and grant checks for the leaf unit.
// Assumes: One clock domain.
// Notes: Bound below to the leaf unit.
`default_nettype none
module vcc_leaf_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic op_busy,
  input wire logic target_rw_grant,
  input wire logic parent_read_grant
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phases taken while the clock enable runs.
  sequence s_rd_req; clk_en && hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr_req; clk_en && hsel && htrans[1] && hready && hwrite; endsequence
  // A start write to control while idle.
  sequence s_start; (s_wr_req and (haddr == 32'h0000_0000 && !op_busy)) ##1 hwdata[0]; endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("Error response seen.");
  a_grant_target: assert property (target_rw_grant == op_busy) else $error("Target grant wrong.");
  a_grant_parent: assert property (parent_read_grant == op_busy) else $error("Parent grant wrong.");
  a_read_wait: assert property (s_rd_req |=> !hreadyout ##1 hreadyout) else $error("Read wait wrong.");
  a_write_nowait: assert property (s_wr_req |=> hreadyout) else $error("Write stalled.");
  a_wait_cause: assert property (!hreadyout |-> $past(hsel && htrans[1] && !hwrite)) else $error("Stray wait.");
  a_start_busy: assert property (s_start |-> ##[1:2] op_busy) else $error("Leaf did not start.");
  a_busy_len: assert property ($rose(op_busy) |=> op_busy ##[1:3] !op_busy) else $error("Leaf run length wrong.");
endmodule // vcc_leaf_chk
bind vcc_leaf_unit vcc_leaf_chk i_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .op_busy(op_busy),
  .target_rw_grant(target_rw_grant), .parent_read_grant(parent_read_grant));
`default_nettype wire

// ===== dv/test_vcc_leaf_unit.sv
// Purpose: Self-checking bench for the child counter leaf unit.
// Assumes: Sixteen pages from BASE, metadata loaded over the bus.
// Notes: A leaf runs for at most four cycles, so each leaf is given eight cycles before status is read.
`default_nettype none
module test_vcc_leaf_unit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] BASE = 64'h0000_0000_0010_0000; // Start of protected page memory.
  // Status: done; done with protection fault; done with enclave page fault.
  localparam logic [31:0] ST_OK = 32'h0000_0002, ST_PROT = 32'h0000_0006, ST_PAGE = 32'h0000_001A;
  localparam logic [31:0] INC = vcc_pkg::LEAF_INC, DEC = vcc_pkg::LEAF_DEC;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_q;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, op_busy, tgt_grant, par_grant;
  int n_errors = 0, check_count = 0;
  // hreadyout is the bus hready.
  vcc_leaf_unit i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_busy(op_busy), .target_rw_grant(tgt_grant),
    .parent_read_grant(par_grant));
  initial forever #5 hclk = ~hclk;
  // Page n of protected memory.
  function automatic logic [63:0] pa(input int n);
    return BASE + (64'(n) << 12);
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single transfer, each phase held until hready.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  // Low counter word of page idx.
  task automatic cnt(input logic [31:0] idx, input logic [31:0] exp);
    wr(vcc_pkg::OFF_META_SEL, idx);
    rdc(vcc_pkg::OFF_CNT_LO, exp);
  endtask
  // One leaf; compares the final status.
  task automatic run(input logic [31:0] leaf, input logic [63:0] t, p, input logic [31:0] ctl, st);
    wr(vcc_pkg::OFF_LEAF, leaf);
    wr(vcc_pkg::OFF_TGT_LO, t[31:0]);
    wr(vcc_pkg::OFF_TGT_HI, t[63:32]);
    wr(vcc_pkg::OFF_PAR_LO, p[31:0]);
    wr(vcc_pkg::OFF_PAR_HI, p[63:32]);
    wr(vcc_pkg::OFF_CTRL, ctl | 32'h0000_0001);
    repeat (8) @(posedge hclk);
    rdc(vcc_pkg::OFF_STATUS, st);
  endtask
  task automatic t_setup;
    // Control, control, regular, busy, invalid, bad type, thread control.
    logic [31:0] mt [7] = '{32'h0000_0101, 32'h0000_0101, 32'h0000_0001, 32'h0000_0002,
      32'h0000_0000, 32'h0000_0301, 32'h0001_0201};
    rdc(vcc_pkg::OFF_FEATURE, 32'h0000_0020);
    rdc(8'h80, 32'h0);
    wr(vcc_pkg::OFF_BASE_LO, BASE[31:0]);
    for (int i = 0; i < 7; i++)
    begin
      wr(vcc_pkg::OFF_META_SEL, i);
      wr(vcc_pkg::OFF_META, mt[i]);
      wr(vcc_pkg::OFF_CNT_LO, (i == 0) ? 32'h1 : 32'h0);
      wr(vcc_pkg::OFF_CNT_HI, 32'h0);
    end
    $display("setup finished");
  endtask
  task automatic t_count;
    wr(vcc_pkg::OFF_FLAGS, 32'h0000_003F);
    run(INC, pa(2), pa(0), 32'h0, ST_OK);
    rdc(vcc_pkg::OFF_FLAGS, 32'h0);
    rdc(vcc_pkg::OFF_RES_LO, 32'h0);
    run(INC, pa(6), pa(1), 32'h0000_0002, ST_OK);
    cnt(1, 32'h1);
    repeat (2) run(DEC, pa(2), pa(0), 32'h0, ST_OK);
    cnt(0, 32'h0);
    run(DEC, pa(2), pa(0), 32'h0, ST_OK);
    rdc(vcc_pkg::OFF_RES_LO, 32'h0000_0002);
    rdc(vcc_pkg::OFF_FLAGS, 32'h0000_0002);
    rdc(vcc_pkg::OFF_CNT_HI, 32'h0);
    run(INC, pa(0), pa(0), 32'h0, ST_OK);
    cnt(0, 32'h1);
    wr(vcc_pkg::OFF_FLAGS, 32'h0000_003F);
    run(DEC, pa(3), pa(0), 32'h0, ST_OK);
    rdc(vcc_pkg::OFF_RES_LO, 32'h0000_0001);
    rdc(vcc_pkg::OFF_FLAGS, 32'h0000_0002);
    $display("counting finished");
  endtask
  task automatic t_faults;
    run(INC, pa(2) + 64'h4, pa(0), 32'h0, ST_PROT);
    run(INC, pa(16), pa(0), 32'h0, ST_PAGE);
    run(INC, pa(2), pa(-1), 32'h0, ST_PAGE);
    run(INC, pa(4), pa(0), 32'h0, ST_PAGE);
    run(INC, pa(5), pa(0), 32'h0, ST_PAGE);
    run(INC, pa(2), pa(1), 32'h0, ST_PROT);
    run(INC, pa(2), pa(2), 32'h0, ST_PAGE);
    run(DEC, pa(2), pa(0), 32'h0000_0030, ST_PROT);
    run(32'h0000_0002, pa(2), pa(0), 32'h0, ST_PROT);
    run(INC, pa(2), pa(0), 32'h0000_0004, ST_PROT);
    run(INC, pa(2) | 64'h8000_0000_0000_0000, pa(0), 32'h0000_0002, ST_PROT);
    wr(vcc_pkg::OFF_DS_LIMIT, 32'h0010_1000);
    run(INC, pa(2), pa(0), 32'h0, ST_PROT);
    cnt(0, 32'h1);
    $display("faults finished");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Reset, then the scenarios.
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_setup;
    t_count;
    t_faults;
    close_out;
  end
  // Watchdog, far beyond the run.
  initial
  begin
    #200000;
    n_errors++;
    close_out;
  end
endmodule // test_vcc_leaf_unit
`default_nettype wire
